// File: lft_pkg.sv
// Shared constants and carrier types for the link flow and recovery logic
package lft_pkg;

  localparam int          SEQ_W    = 7;
  localparam logic [6:0]  SEQ_ZERO = 7'h00;
  localparam logic [6:0]  SEQ_ONE  = 7'h01;
  localparam logic [1:0]  CNT_ZERO = 2'h0;
  localparam logic [1:0]  CNT_ONE  = 2'h1;
  // Retry limit before re-establishment
  localparam logic [1:0]  N200     = 2'h3;

  localparam int T200_MS     = 1000;
  localparam int CLK_HZ      = 20_000_000;
  localparam int T200_CYCLES = T200_MS * (CLK_HZ / 1000);
  localparam int T200_W      = 25;

  typedef enum logic [2:0] {
    FK_I     = 3'h0,
    FK_RR    = 3'h1,
    FK_RNR   = 3'h2,
    FK_REJ   = 3'h3,
    FK_SABME = 3'h4,
    FK_DM    = 3'h5,
    FK_FRMR  = 3'h6,
    FK_UA    = 3'h7
  } lft_kind_type;

  typedef enum logic [1:0] {
    SK_RR  = 2'h0,
    SK_RNR = 2'h1,
    SK_REJ = 2'h2
  } lft_sup_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EST  = 3'h2,
    ST_REC  = 3'h4
  } lft_state_type;

  // One received, already validated frame; valid is a one-cycle pulse
  typedef struct packed {
    logic         valid;
    lft_kind_type kind;
    logic         cmd;
    logic         pf;
    logic [6:0]   nr;
  } lft_rx_type;

  // Supervisory frame request held until the transmitter takes it
  typedef struct packed {
    logic        valid;
    lft_sup_type kind;
    logic        cmd;
    logic        pf;
  } lft_txreq_type;

endpackage

// File: lft_t200.sv
// Acknowledgement timer with restart, stop and expiry pulse
module lft_t200 import lft_pkg::*; #(
  parameter int unsigned CYCLES = T200_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic start,
  input  wire logic stop,
  output logic      running,
  output logic      expired
);

  logic [T200_W-1:0] cnt;

  // Start beats stop so that reset-and-restart works in one cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      running <= 1'b0;
      expired <= 1'b0;
      cnt     <= '0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        running <= 1'b1;
        cnt     <= T200_W'(CYCLES - 1);
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        if (cnt == '0) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt <= cnt - T200_W'(1);
        end
      end
    end
  end

endmodule

// File: lft_sup_select.sv
// Picks the appropriate supervisory frame type
module lft_sup_select import lft_pkg::*; (
  input  wire logic  own_busy,
  input  wire logic  seq_err,
  input  wire logic  rej_sent,
  output lft_sup_type kind
);

  always_comb begin
    if (own_busy) begin
      kind = SK_RNR;
    end else if (seq_err && !rej_sent) begin
      kind = SK_REJ;
    end else begin
      kind = SK_RR;
    end
  end

endmodule

// File: lft_link_recovery.sv
// Peer busy, timer recovery and re-establishment control of a link entity
module lft_link_recovery import lft_pkg::*; #(
  parameter int unsigned T200_CYCLES_P = T200_CYCLES
) (
  input  wire logic    ref_clk,
  input  wire logic    sys_rst,
  input  lft_rx_type   rx_frame,
  input  wire logic    frame_reject,
  input  wire logic    est_req,
  input  wire logic    est_done,
  input  wire logic    mode_setting,
  input  wire logic    own_busy,
  input  wire logic    seq_err,
  input  wire logic    rej_sent,
  input  wire logic    i_sent,
  input  wire logic    sabme_ua_sent,
  input  wire logic    poll_with_i,
  input  wire logic    sup_ack,
  output lft_txreq_type sup_req,
  output logic         retx_i_req,
  output logic         i_allowed,
  output logic         peer_busy,
  output logic         timer_rec,
  output logic [1:0]   retx_cnt,
  output logic [6:0]   vs,
  output logic [6:0]   va,
  output logic         reestablish,
  output logic         mdl_error,
  output logic         t200_running
);

  lft_state_type state;
  logic          poll_out;
  logic          busy_told;
  logic          own_busy_q;
  logic          t200_exp;
  logic          t200_start;
  logic          t200_stop;
  lft_sup_type   sel_kind;
  lft_txreq_type next_req;

  logic       est;
  logic       is_sup;
  logic       has_nr;
  logic       nr_ok;
  logic       nr_err;
  logic       f1_resp;
  logic       poll_in;
  logic       rx_rnr;
  logic       rx_clr;
  logic       exp_go;
  logic       exp_last;
  logic       re_peer;
  logic       re_any;
  logic [1:0] next_cnt;
  logic [6:0] d_nr;
  logic [6:0] d_vs;

  lft_t200 #(
    .CYCLES (T200_CYCLES_P)
  ) u_t200 (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (t200_start),
    .stop    (t200_stop),
    .running (t200_running),
    .expired (t200_exp)
  );

  lft_sup_select u_sel (
    .own_busy (own_busy),
    .seq_err  (seq_err),
    .rej_sent (rej_sent),
    .kind     (sel_kind)
  );

  // Modulo distances keep the range check correct across wrap
  always_comb begin
    d_nr = rx_frame.nr - va;
    d_vs = vs - va;
    nr_ok = d_nr <= d_vs;
    est = state != ST_IDLE;
    is_sup = rx_frame.kind == FK_RR || rx_frame.kind == FK_RNR ||
             rx_frame.kind == FK_REJ;
    has_nr = rx_frame.valid && est && (is_sup || rx_frame.kind == FK_I);
    nr_err = has_nr && !nr_ok;
    f1_resp = has_nr && nr_ok && is_sup && !rx_frame.cmd && rx_frame.pf;
    rx_rnr = has_nr && nr_ok && rx_frame.kind == FK_RNR;
    rx_clr = has_nr && nr_ok &&
             (rx_frame.kind == FK_RR || rx_frame.kind == FK_REJ);
    // Polls we answer: supervisory always, I frames only while busy
    poll_in = has_nr && nr_ok && rx_frame.cmd && rx_frame.pf &&
              (is_sup || own_busy);
    next_cnt = (state == ST_REC) ? retx_cnt + CNT_ONE : CNT_ZERO;
    exp_go = t200_exp && est && next_cnt < N200;
    exp_last = t200_exp && est && next_cnt == N200;
    re_peer = rx_frame.valid && est &&
              (rx_frame.kind == FK_SABME || rx_frame.kind == FK_FRMR ||
               (rx_frame.kind == FK_DM && !rx_frame.cmd &&
                !rx_frame.pf));
    re_peer = re_peer || (rx_frame.valid && state == ST_REC &&
              rx_frame.kind == FK_DM && !rx_frame.cmd &&
              rx_frame.pf);
    re_peer = re_peer || exp_last || nr_err ||
              (frame_reject && est);
    re_any = re_peer || est_req;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (est_done) begin
            state <= ST_EST;
          end
        end
        ST_EST: begin
          if (re_any) begin
            state <= ST_IDLE;
          end else if (exp_go) begin
            state <= ST_REC;
          end
        end
        ST_REC: begin
          if (re_any) begin
            state <= ST_IDLE;
          end else if (f1_resp) begin
            state <= ST_EST;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      retx_cnt <= CNT_ZERO;
    end else if (est_done || re_any) begin
      retx_cnt <= CNT_ZERO;
    end else if (t200_exp && est) begin
      retx_cnt <= next_cnt;
    end
  end

  // Set wins over clear; both cannot come from one frame anyway
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      peer_busy <= 1'b0;
    end else if (rx_rnr && !mode_setting) begin
      peer_busy <= 1'b1;
    end else if (rx_clr) begin
      peer_busy <= 1'b0;
    end else if (rx_frame.valid && rx_frame.kind == FK_SABME) begin
      peer_busy <= 1'b0;
    end else if (est_done) begin
      peer_busy <= 1'b0;
    end
  end

  // An RNR final leaves the enquiry open, so I frames keep waiting
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      poll_out <= 1'b0;
    end else if (re_any || est_done) begin
      poll_out <= 1'b0;
    end else if (exp_go) begin
      poll_out <= 1'b1;
    end else if (f1_resp && rx_frame.kind != FK_RNR) begin
      poll_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      va <= SEQ_ZERO;
    end else if (est_done) begin
      va <= SEQ_ZERO;
    end else if (has_nr && nr_ok) begin
      va <= rx_frame.nr;
    end
  end

  // Commands never move V(S); of received frames only an in-range supervisory F=1 response does
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vs <= SEQ_ZERO;
    end else if (est_done) begin
      vs <= SEQ_ZERO;
    end else if (f1_resp) begin
      vs <= rx_frame.nr;
    end else if (i_sent) begin
      vs <= vs + SEQ_ONE;
    end
  end

  always_comb begin
    t200_start = (i_sent && !t200_running) || exp_go;
    t200_start = t200_start ||
                 (rx_rnr && (!poll_out || f1_resp));
    t200_stop = est_done || re_any ||
                (f1_resp && rx_frame.kind != FK_RNR);
  end

  // Priority: poll answer, own poll, busy entry, busy exit
  always_comb begin
    next_req = '0;
    if (poll_in) begin
      next_req = {1'b1, sel_kind, 1'b0, 1'b1};
    end else if (exp_go && !(poll_with_i && vs != va)) begin
      next_req = {1'b1, sel_kind, 1'b1, 1'b1};
    end else if (own_busy && !own_busy_q) begin
      next_req = {1'b1, SK_RNR, 1'b0, 1'b0};
    end else if (!own_busy && own_busy_q && busy_told) begin
      next_req = {1'b1, sel_kind, 1'b0, 1'b0};
    end
  end

  // A pending F=1 answer is never displaced by a weaker request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sup_req <= '0;
    end else if (next_req.valid &&
                 (!sup_req.valid || sup_ack || sup_req.cmd ||
                  !sup_req.pf || next_req.pf)) begin
      sup_req <= next_req;
    end else if (sup_ack) begin
      sup_req <= '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      own_busy_q <= 1'b0;
    end else begin
      own_busy_q <= own_busy;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busy_told <= 1'b0;
    end else if (next_req.valid && next_req.kind == SK_RNR) begin
      busy_told <= 1'b1;
    end else if (sabme_ua_sent || (!own_busy && own_busy_q)) begin
      busy_told <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      retx_i_req <= 1'b0;
    end else begin
      retx_i_req <= exp_go && poll_with_i && vs != va;
    end
  end

  // I frames held through peer busy and the whole enquiry
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      i_allowed <= 1'b0;
    end else begin
      i_allowed <= state == ST_EST && !peer_busy && !poll_out;
    end
  end

  // Layer 3 requests get no error indication, only re-establishment
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reestablish <= 1'b0;
      mdl_error   <= 1'b0;
    end else begin
      reestablish <= re_any;
      mdl_error   <= re_peer;
    end
  end

  always_comb begin
    timer_rec = state == ST_REC;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_rnr_poll_reply: assert property (
    rx_frame.valid && rx_frame.kind == FK_RNR && rx_frame.cmd &&
    rx_frame.pf && has_nr && nr_ok && !seq_err |=>
    sup_req.valid && !sup_req.cmd && sup_req.pf &&
    sup_req.kind == ($past(own_busy) ? SK_RNR : SK_RR))
    else $error("RNR poll not answered correctly");

  chk_rnr_final_vs: assert property (
    f1_resp && rx_frame.kind == FK_RNR && !re_any |=>
    vs == $past(rx_frame.nr) && state == ST_EST)
    else $error("RNR final did not end recovery");

  chk_peer_busy_set: assert property (
    rx_rnr && !mode_setting |=> peer_busy ##1 !i_allowed)
    else $error("peer busy not recorded");

  chk_va_follows_nr: assert property (
    has_nr && nr_ok && !est_done |=> va == $past(rx_frame.nr))
    else $error("V(A) not updated");

  chk_expiry_enters: assert property (
    t200_exp && state == ST_EST && !re_any |=>
    state == ST_REC && retx_cnt == CNT_ZERO && poll_out)
    else $error("expiry did not enter recovery");

  chk_expiry_counts: assert property (
    t200_exp && state == ST_REC && !re_any |=>
    retx_cnt == $past(retx_cnt) + CNT_ONE && t200_running)
    else $error("retry count not advanced");

  chk_n200_reestab: assert property (
    t200_exp && state == ST_REC && retx_cnt + CNT_ONE == N200 |=>
    reestablish && mdl_error ##1 !reestablish)
    else $error("N200 failure not escalated");

  chk_sabme_clears: assert property (
    rx_frame.valid && rx_frame.kind == FK_SABME |=> !peer_busy)
    else $error("SABME left peer busy");

  chk_busy_entry_rnr: assert property (
    own_busy && !own_busy_q && !poll_in && !exp_go |=>
    sup_req.valid && sup_req.kind == SK_RNR && !sup_req.pf)
    else $error("busy entry without RNR");

  chk_final_stops_t200: assert property (
    f1_resp && rx_frame.kind == FK_RR && !i_sent |=>
    !t200_running [*2])
    else $error("T200 kept after RR final");

endmodule

// File: lft_peer_model.sv
// Peer link entity model: sends frames, takes and answers requests
module lft_peer_model import lft_pkg::*; (
  input  wire logic       ref_clk,
  input  lft_txreq_type   sup_req,
  input  wire logic       answer_polls,
  input  wire logic       busy,
  input  wire logic [6:0] reply_nr,
  input  wire logic [1:0] ack_delay,
  output lft_rx_type      rx_frame,
  output logic            sup_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  lft_txreq_type taken = '0;
  int            n_taken = 0;
  int            wait_cnt = 0;
  int            reply_req = 0;
  int            reply_done = 0;

  initial begin
    rx_frame = '0;
    sup_ack = 1'b0;
  end

  // Idle fields other than kind carry inverted junk so stale values are never reused
  task automatic send_frame(input lft_kind_type k, input logic c,
                            input logic p, input logic [6:0] nr);
    @(negedge ref_clk);
    rx_frame <= {1'b1, k, c, p, nr};
    @(negedge ref_clk);
    rx_frame <= {1'b0, k, ~c, ~p, ~nr};
  endtask

  always @(negedge ref_clk) begin
    if (sup_ack) begin
      sup_ack <= 1'b0;
    end else if (sup_req.valid && wait_cnt >= ack_delay) begin
      sup_ack <= 1'b1;
      taken <= sup_req;
      n_taken <= n_taken + 1;
      wait_cnt <= 0;
      if (answer_polls && sup_req.cmd && sup_req.pf) begin
        reply_req <= reply_req + 1;
      end
    end else if (sup_req.valid) begin
      wait_cnt <= wait_cnt + 1;
    end
  end

  // Poll answer shows whether this side is still busy
  always @(negedge ref_clk) begin
    if (reply_req != reply_done) begin
      reply_done = reply_done + 1;
      send_frame(busy ? FK_RNR : FK_RR, 1'b0, 1'b1, reply_nr);
    end
  end
endmodule

// File: lft_link_recovery_tb.sv
// Self-checking bench for the link flow and recovery block
module lft_link_recovery_tb import lft_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 200;
  logic ref_clk = 0, sys_rst = 1, frame_reject = 0, est_req = 0;
  logic est_done = 0, mode_setting = 0, own_busy = 0, seq_err = 0;
  logic rej_sent = 0, i_sent = 0, sabme_ua_sent = 0, poll_with_i = 0;
  logic sup_ack, retx_i_req, i_allowed, peer_busy, timer_rec;
  logic reestablish, mdl_error, t200_running;
  logic answer_polls = 0, pbusy = 0;
  logic [6:0] reply_nr = 0, vs, va;
  logic [1:0] ack_delay = 2, retx_cnt;
  lft_rx_type    rx_frame;
  lft_txreq_type sup_req;
  int error_cnt = 0, cmp_count = 0, n_re = 0, n_mdl = 0, n_retx = 0;

  lft_link_recovery #(.T200_CYCLES_P(T)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .rx_frame(rx_frame),
    .frame_reject(frame_reject), .est_req(est_req), .est_done(est_done),
    .mode_setting(mode_setting), .own_busy(own_busy), .seq_err(seq_err),
    .rej_sent(rej_sent), .i_sent(i_sent), .sabme_ua_sent(sabme_ua_sent),
    .poll_with_i(poll_with_i), .sup_ack(sup_ack), .sup_req(sup_req),
    .retx_i_req(retx_i_req), .i_allowed(i_allowed),
    .peer_busy(peer_busy), .timer_rec(timer_rec), .retx_cnt(retx_cnt),
    .vs(vs), .va(va), .reestablish(reestablish), .mdl_error(mdl_error),
    .t200_running(t200_running));

  lft_peer_model i_peer (
    .ref_clk(ref_clk), .sup_req(sup_req), .answer_polls(answer_polls),
    .busy(pbusy), .reply_nr(reply_nr), .ack_delay(ack_delay),
    .rx_frame(rx_frame), .sup_ack(sup_ack));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  // One-cycle pulses are counted so checks need not hit their cycle
  always @(posedge ref_clk) begin
    if (reestablish === 1'b1) n_re <= n_re + 1;
    if (mdl_error === 1'b1) n_mdl <= n_mdl + 1;
    if (retx_i_req === 1'b1) n_retx <= n_retx + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
  endtask

  // Needs ack_delay above zero so the count is read before the take
  task automatic exp_sup(input lft_sup_type k, input logic c,
                         input logic p);
    int n;
    n = i_peer.n_taken;
    for (int i = 0; i < 20 && i_peer.n_taken == n; i++) @(negedge ref_clk);
    chk({n != i_peer.n_taken, 3'h0, i_peer.taken.kind, i_peer.taken.cmd,
         i_peer.taken.pf}, {4'h8, k, c, p});
  endtask

  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic t_peer_busy();
    int n;
    repeat (3) pulse(i_sent);
    mode_setting = 1'b1;
    i_peer.send_frame(FK_RNR, 1'b1, 1'b0, 7'h00);
    chk({7'h0, peer_busy}, 8'h00);
    mode_setting = 1'b0;
    i_peer.send_frame(FK_RNR, 1'b1, 1'b1, 7'h02);
    exp_sup(SK_RR, 1'b0, 1'b1);
    chk({1'b0, va}, 8'h02);
    chk({1'b0, vs}, 8'h03);
    chk({5'h0, peer_busy, i_allowed, t200_running}, 8'h05);
    own_busy = 1'b1;
    exp_sup(SK_RNR, 1'b0, 1'b0);
    i_peer.send_frame(FK_REJ, 1'b1, 1'b1, 7'h02);
    exp_sup(SK_RNR, 1'b0, 1'b1);
    chk({7'h0, peer_busy}, 8'h00);
    i_peer.send_frame(FK_I, 1'b1, 1'b1, 7'h03);
    exp_sup(SK_RNR, 1'b0, 1'b1);
    chk({1'b0, va}, 8'h03);
    seq_err = 1'b1;
    own_busy = 1'b0;
    exp_sup(SK_REJ, 1'b0, 1'b0);
    i_peer.send_frame(FK_RR, 1'b1, 1'b1, 7'h03);
    exp_sup(SK_REJ, 1'b0, 1'b1);
    rej_sent = 1'b1;
    i_peer.send_frame(FK_RR, 1'b1, 1'b1, 7'h03);
    exp_sup(SK_RR, 1'b0, 1'b1);
    seq_err = 1'b0;
    rej_sent = 1'b0;
    own_busy = 1'b1;
    exp_sup(SK_RNR, 1'b0, 1'b0);
    pulse(sabme_ua_sent);
    own_busy = 1'b0;
    n = i_peer.n_taken;
    repeat (6) @(negedge ref_clk);
    chk({7'h0, i_peer.n_taken != n}, 8'h00);
  endtask

  task automatic t_timer();
    pulse(i_sent);
    for (int i = 0; i < 1000 && timer_rec !== 1'b1; i++) @(negedge ref_clk);
    chk({6'h0, retx_cnt}, 8'h00);
    exp_sup(SK_RR, 1'b1, 1'b1);
    poll_with_i = 1'b1;
    for (int i = 0; i < 300 && retx_cnt !== 2'h1; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    chk(n_retx[7:0], 8'h01);
    chk({7'h0, t200_running}, 8'h01);
    poll_with_i = 1'b0;
    for (int i = 0; i < 300 && retx_cnt !== 2'h2; i++) @(negedge ref_clk);
    exp_sup(SK_RR, 1'b1, 1'b1);
    for (int i = 0; i < 300 && n_re == 0; i++) @(negedge ref_clk);
    chk({n_re[3:0], n_mdl[3:0]}, 8'h11);
  endtask

  task automatic recover(input logic busy_peer, input logic [6:0] nr);
    pbusy = busy_peer;
    reply_nr = nr;
    pulse(i_sent);
    for (int i = 0; i < 1000 && timer_rec !== 1'b1; i++) @(negedge ref_clk);
    for (int i = 0; i < 50 && timer_rec !== 1'b0; i++) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic t_recovery();
    pulse(est_done);
    ack_delay = 2'h0;
    answer_polls = 1'b1;
    pulse(i_sent);
    recover(1'b0, 7'h01);
    chk({1'b0, vs}, 8'h01);
    chk({5'h0, peer_busy, t200_running, i_allowed}, 8'h01);
    recover(1'b1, 7'h02);
    chk({1'b0, vs}, 8'h02);
    chk({6'h0, peer_busy, t200_running}, 8'h03);
    answer_polls = 1'b0;
    ack_delay = 2'h2;
    i_peer.send_frame(FK_RR, 1'b1, 1'b0, 7'h02);
    @(negedge ref_clk);
    chk({6'h0, peer_busy, i_allowed}, 8'h00);
  endtask

  task automatic t_reest();
    int n;
    int m;
    for (int e = 0; e < 7; e++) begin
      pulse(est_done);
      i_peer.send_frame(FK_RNR, 1'b0, 1'b0, 7'h00);
      n = n_re;
      m = n_mdl;
      case (e)
        0: i_peer.send_frame(FK_SABME, 1'b1, 1'b1, 7'h00);
        1: i_peer.send_frame(FK_DM, 1'b0, 1'b0, 7'h00);
        2: i_peer.send_frame(FK_FRMR, 1'b0, 1'b0, 7'h00);
        3: pulse(frame_reject);
        4: pulse(est_req);
        5: i_peer.send_frame(FK_RR, 1'b0, 1'b0, 7'h05);
        default: begin
          for (int i = 0; i < 300 && timer_rec !== 1'b1; i++)
            @(negedge ref_clk);
          i_peer.send_frame(FK_DM, 1'b0, 1'b1, 7'h00);
        end
      endcase
      repeat (2) @(negedge ref_clk);
      n = n_re - n;
      m = n_mdl - m;
      chk({n[3:0], m[3:0]}, {4'h1, 3'h0, e != 4});
      if (e == 0) chk({7'h0, peer_busy}, 8'h00);
    end
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'b0;
    pulse(est_done);
    t_peer_busy();
    t_timer();
    t_recovery();
    t_reest();
    end_sim();
  end
endmodule
